// ---- verilog/ubd_map.vh ----
`ifndef UBD_MAP_VH
`define UBD_MAP_VH
// register byte offsets; descriptors fill 0x000..0x0FC, one word each
`define UBD_OFS_CTRL 10'h100
`define UBD_OFS_STAT 10'h104
`define UBD_OFS_MASK 10'h108
`define UBD_OFS_EPST 10'h10C
// descriptor field positions
`define UBD_BIT_OWN 31
`define UBD_BIT_TOG 30
`define UBD_PID_HI 29
`define UBD_PID_LO 26
`define UBD_BIT_SYNC 27
`define UBD_BIT_STALL 26
`define UBD_CNT_HI 25
`define UBD_CNT_LO 16
`define UBD_ADR_HI 15
`define UBD_ADR_LO 0
// token, handshake, data and status codes written into the pid field
`define UBD_TOK_OUT 4'h1
`define UBD_TOK_IN 4'h9
`define UBD_TOK_SETUP 4'hD
`define UBD_HS_ACK 4'h2
`define UBD_HS_STALL 4'hE
`define UBD_HS_NAK 4'hA
`define UBD_PID_DATA0 4'h3
`define UBD_PID_DATA1 4'hB
`define UBD_ST_TIMEOUT 4'h0
`define UBD_ST_DATAERR 4'hF
// host-mode transfer results from the link
`define UBD_RES_ACK 3'h0
`define UBD_RES_STALL 3'h1
`define UBD_RES_NAK 3'h2
`define UBD_RES_DATA0 3'h3
`define UBD_RES_DATA1 3'h4
`define UBD_RES_TIMEOUT 3'h5
`define UBD_RES_DATAERR 3'h6
// answers to a token
`define UBD_ANS_NONE 2'h0
`define UBD_ANS_GO 2'h1
`define UBD_ANS_NAK 2'h2
`define UBD_ANS_STALL 2'h3
// event bits of status and mask
`define UBD_EV_DONE 0
`define UBD_EV_STALL 1
`define UBD_EV_NAK 2
`define UBD_EV_SYNC 3
// reset values
`define UBD_CTRL_RST 1'h0
`define UBD_MASK_RST 4'h0
`define UBD_STAT_RST 4'h0
`define UBD_EPST_RST 16'h0000
`endif

// ---- verilog/ubd_desc_mem.v ----
`timescale 1ns/10ps
`default_nettype none
// descriptor store, byte-lane writes, registered read data
module ubd_desc_mem #(
    parameter AW = 6
) (
    input wire clk,
    input wire [3:0] we,
    input wire [AW-1:0] addr,
    input wire [31:0] wdata,
    output reg [31:0] rdata
);
    reg [31:0] mem [0:(1<<AW)-1]; // descriptor words
    integer i;

    // write enabled lanes, read old word
    always @(posedge clk) begin
        for (i = 0; i < 4; i = i + 1) begin
            if (we[i]) begin
                mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

// ---- verilog/ubd_descriptor_engine.v ----
// How it works
// - owned flag set: engine holds descriptor, software waits
// - owned flag clear: engine ignores other fields
// - toggle bit picks DATA1/DATA0 sent and expected
// - sync enabled: mismatched received data pid discarded
// - receive writeback stores received data toggle
// - transmit writeback keeps software toggle bit
// - device mode writes token pid on completion
// - host mode reports ACK, STALL, NAK handshake
// - host mode reports DATA0 0x3, DATA1 0xB
// - host mode timeout 0x0, data error 0xF
// - byte count replaced by actual transferred count
// - buffer address kept unchanged on writeback
// - stall enable: answer STALL, flag endpoint, keep
// - completion clears owned flag for software
// - software-owned receive descriptor answers NAK
// - device toggle mismatch answers NAK to resync
`timescale 1ns/10ps
`default_nettype none
`include "ubd_map.vh"
module ubd_descriptor_engine #(
    parameter AW = 6
) (
    input wire ref_clk,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire tokValid,
    input wire [AW-1:0] tokEntry,
    input wire [3:0] tokPid,
    output wire ansValid,
    output wire [1:0] ansCode,
    output wire [9:0] ansCount,
    output wire [15:0] ansAddr,
    output wire [3:0] ansTxPid,
    input wire doneValid,
    input wire [9:0] doneCount,
    input wire [3:0] doneRxPid,
    input wire [2:0] doneRes,
    output wire syncNak,
    output wire [15:0] endpoint_stall_flag,
    output wire irq
);
    // engine states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DECIDE = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;

    // host-mode result to pid field code
    // codes outside the table report a data error
    function [3:0] hostCode;
        input [2:0] res;
        begin
            case (res)
                `UBD_RES_ACK: hostCode = `UBD_HS_ACK;
                `UBD_RES_STALL: hostCode = `UBD_HS_STALL;
                `UBD_RES_NAK: hostCode = `UBD_HS_NAK;
                `UBD_RES_DATA0: hostCode = `UBD_PID_DATA0;
                `UBD_RES_DATA1: hostCode = `UBD_PID_DATA1;
                `UBD_RES_TIMEOUT: hostCode = `UBD_ST_TIMEOUT;
                default: hostCode = `UBD_ST_DATAERR;
            endcase
        end
    endfunction

    // true when this token moves data into the buffer
    // device mode: OUT and SETUP fill the buffer; host mode: IN does
    function isRecv;
        input [3:0] pid;
        input host;
        begin
            if (host) begin
                isRecv = (pid == `UBD_TOK_IN);
            end else begin
                isRecv = (pid != `UBD_TOK_IN);
            end
        end
    endfunction

    // state and registers
    reg [1:0] state_r; // engine state
    reg tokPend_r; // token waiting for engine
    reg [AW-1:0] tokEntry_r; // captured entry index
    reg [3:0] tokPid_r; // captured token pid
    // a token may arrive mid-transfer; the one in service keeps its own copy
    reg [AW-1:0] curEntry_r; // entry under service
    reg [3:0] curPid_r; // token pid under service
    reg [31:0] desc_r; // descriptor under use
    reg ansValid_r; // answer strobe
    reg [1:0] ansCode_r;
    reg [9:0] ansCount_r;
    reg [15:0] ansAddr_r;
    reg [3:0] ansTxPid_r;
    reg syncNak_r; // toggle mismatch strobe
    reg hostMode_r; // control: host mode
    reg [3:0] stat_r; // sticky events
    reg [3:0] mask_r; // event enables
    reg [15:0] endpoint_stall_flag_r; // per endpoint stall flags
    reg busBusy_r; // bus access in flight
    reg busWe_r; // latched direction
    reg [9:0] busAdr_r; // latched address
    reg ack_r; // bus ack
    reg [31:0] dat_r; // bus read data
    reg [3:0] evSet; // events this cycle

    // memory port wires
    wire [31:0] memQ;
    reg [3:0] memWe;
    reg [AW-1:0] memAddr;
    reg [31:0] memD;

    // decode helpers
    // the bus waits while the engine serves a token; no request is lost,
    // the ack simply comes later
    wire busReq = wb_cyc_i & wb_stb_i & ~busBusy_r & ~ack_r & (state_r == ST_IDLE) &
        ~tokPend_r & ~tokValid;
    wire busDesc = (wb_adr_i[9:8] == 2'h0);
    wire startGo = (state_r == ST_IDLE) & tokPend_r & ~busBusy_r;
    wire recvTok = isRecv(curPid_r, hostMode_r);
    wire rxTog = (doneRxPid == `UBD_PID_DATA1);
    wire togBad = recvTok & desc_r[`UBD_BIT_SYNC] & (rxTog != desc_r[`UBD_BIT_TOG]);
    wire [3:0] epIdx = curEntry_r[AW-1:AW-4];

    // descriptor store, one word per entry
    // descriptor words are not reset; software must clear the owned flags
    // before it hands out any token
    ubd_desc_mem #(
        .AW(AW)
    ) u_mem (
        .clk(ref_clk),
        .we(memWe),
        .addr(memAddr),
        .wdata(memD),
        .rdata(memQ)
    );

    // memory port arbitration, engine first
    // bus and engine requests exclude each other: the bus is taken only with
    // no token pending, and a pending token starts only once the bus is quiet
    always @* begin
        memWe = 4'h0;
        memAddr = wb_adr_i[AW+1:2];
        memD = wb_dat_i;
        if (startGo) begin
            memAddr = tokEntry_r;
        end else if (state_r != ST_IDLE) begin
            memAddr = curEntry_r;
            memD = desc_r;
            memD[`UBD_BIT_OWN] = 1'b0;
            if (recvTok) begin
                memD[`UBD_BIT_TOG] = rxTog;
            end
            // transmit leaves the toggle bit as software left it
            if (hostMode_r) begin
                memD[`UBD_PID_HI:`UBD_PID_LO] = hostCode(doneRes);
            end else begin
                memD[`UBD_PID_HI:`UBD_PID_LO] = curPid_r;
            end
            memD[`UBD_CNT_HI:`UBD_CNT_LO] = doneCount;
            // buffer address bits pass through from desc_r
            if ((state_r == ST_WAIT) & doneValid & ~togBad) begin
                memWe = 4'hF;
            end
        end else if (busReq & busDesc & wb_we_i) begin
            memWe = wb_sel_i;
        end
    end

    // token capture and engine sequence
    // a token pulse is captured even while the engine is busy; the newest
    // one overwrites an unserved one, since the link only retries the last
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            tokPend_r <= 1'b0;
            tokEntry_r <= {AW{1'b0}};
            tokPid_r <= 4'h0;
            curEntry_r <= {AW{1'b0}};
            curPid_r <= 4'h0;
            desc_r <= 32'h0000_0000;
            ansValid_r <= 1'b0;
            ansCode_r <= `UBD_ANS_NONE;
            ansCount_r <= 10'h000;
            ansAddr_r <= 16'h0000;
            ansTxPid_r <= 4'h0;
            syncNak_r <= 1'b0;
        end else begin
            ansValid_r <= 1'b0;
            syncNak_r <= 1'b0;
            // latest token wins while one is pending
            if (tokValid) begin
                tokPend_r <= 1'b1;
                tokEntry_r <= tokEntry;
                tokPid_r <= tokPid;
            end
            case (state_r)
                ST_IDLE: begin
                    if (startGo & ~tokValid) begin
                        // take the pending token into service
                        tokPend_r <= 1'b0;
                        curEntry_r <= tokEntry_r;
                        curPid_r <= tokPid_r;
                        state_r <= ST_DECIDE;
                    end
                end
                ST_DECIDE: begin
                    desc_r <= memQ;
                    ansValid_r <= 1'b1;
                    ansCount_r <= memQ[`UBD_CNT_HI:`UBD_CNT_LO];
                    ansAddr_r <= memQ[`UBD_ADR_HI:`UBD_ADR_LO];
                    ansTxPid_r <= memQ[`UBD_BIT_TOG] ? `UBD_PID_DATA1 : `UBD_PID_DATA0;
                    if (!memQ[`UBD_BIT_OWN]) begin
                        // software owns it: other fields not looked at
                        ansCode_r <= `UBD_ANS_NAK;
                        state_r <= ST_IDLE;
                    end else if (memQ[`UBD_BIT_STALL]) begin
                        // descriptor left untouched, still owned
                        ansCode_r <= `UBD_ANS_STALL;
                        state_r <= ST_IDLE;
                    end else begin
                        // engine holds the descriptor until done
                        ansCode_r <= `UBD_ANS_GO;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // a pending token waits here; it is served once idle again
                    if (doneValid) begin
                        // mismatch: packet dropped, descriptor kept
                        syncNak_r <= togBad & ~hostMode_r;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // events raised by the engine
    // event strobes are one cycle wide and feed the sticky status
    always @* begin
        evSet = 4'h0;
        evSet[`UBD_EV_DONE] = (state_r == ST_WAIT) & doneValid & ~togBad;
        evSet[`UBD_EV_STALL] = (state_r == ST_DECIDE) & memQ[`UBD_BIT_OWN] &
            memQ[`UBD_BIT_STALL];
        evSet[`UBD_EV_NAK] = (state_r == ST_DECIDE) & ~memQ[`UBD_BIT_OWN];
        evSet[`UBD_EV_SYNC] = (state_r == ST_WAIT) & doneValid & togBad;
    end

    // wishbone slave: accept, then ack one cycle later
    // the master holds address and data until ack, so register writes
    // may still use the live bus inputs at the ack-launching edge
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            busBusy_r <= 1'b0;
            busWe_r <= 1'b0;
            busAdr_r <= 10'h000;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= 1'b0;
            if (busReq) begin
                busBusy_r <= 1'b1;
                busWe_r <= wb_we_i;
                busAdr_r <= wb_adr_i;
            end else if (busBusy_r) begin
                busBusy_r <= 1'b0;
                ack_r <= 1'b1;
                dat_r <= 32'h0000_0000;
                if (!busWe_r) begin
                    if (busAdr_r[9:8] == 2'h0) begin
                        dat_r <= memQ;
                    end else if (busAdr_r == `UBD_OFS_CTRL) begin
                        dat_r[0] <= hostMode_r;
                    end else if (busAdr_r == `UBD_OFS_STAT) begin
                        dat_r[3:0] <= stat_r;
                    end else if (busAdr_r == `UBD_OFS_MASK) begin
                        dat_r[3:0] <= mask_r;
                    end else if (busAdr_r == `UBD_OFS_EPST) begin
                        dat_r[15:0] <= endpoint_stall_flag_r;
                    end
                end
            end
        end
    end

    // control, mask, sticky status and stall flags
    // hazard: a status read and a new event in one cycle keep the event
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            hostMode_r <= `UBD_CTRL_RST;
            mask_r <= `UBD_MASK_RST;
            stat_r <= `UBD_STAT_RST;
            endpoint_stall_flag_r <= `UBD_EPST_RST;
        end else begin
            // read clears status, a new event wins
            if (busBusy_r & ~busWe_r & (busAdr_r == `UBD_OFS_STAT)) begin
                stat_r <= evSet;
            end else begin
                stat_r <= stat_r | evSet;
            end
            if (busBusy_r & busWe_r & wb_sel_i[0]) begin
                if (busAdr_r == `UBD_OFS_CTRL) begin
                    hostMode_r <= wb_dat_i[0];
                end
                if (busAdr_r == `UBD_OFS_MASK) begin
                    mask_r <= wb_dat_i[3:0];
                end
            end
            // write one clears a flag, stall set wins
            if (busBusy_r & busWe_r & (busAdr_r == `UBD_OFS_EPST)) begin
                endpoint_stall_flag_r <= (endpoint_stall_flag_r & ~({{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} &
                    wb_dat_i[15:0])) | ({16{evSet[`UBD_EV_STALL]}} & (16'h0001 << epIdx));
            end else if (evSet[`UBD_EV_STALL]) begin
                endpoint_stall_flag_r <= endpoint_stall_flag_r | (16'h0001 << epIdx);
            end
        end
    end

    // outputs
    // irq is a plain level; it falls once status is read or masked
    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign ansValid = ansValid_r;
    assign ansCode = ansCode_r;
    assign ansCount = ansCount_r;
    assign ansAddr = ansAddr_r;
    assign ansTxPid = ansTxPid_r;
    assign syncNak = syncNak_r;
    assign endpoint_stall_flag = endpoint_stall_flag_r;
    assign irq = |(stat_r & mask_r);
endmodule
`default_nettype wire

// ---- verif/ubd_engine_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ubd_map.vh"
// protocol watch on the engine's ports
module ubd_engine_chk #(
    parameter AW = 6
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic ansValid,
    input wire logic [1:0] ansCode,
    input wire logic [9:0] ansCount,
    input wire logic [3:0] ansTxPid,
    input wire logic doneValid,
    input wire logic syncNak,
    input wire logic [15:0] endpoint_stall_flag
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held past one cycle");
    a_ack_after_req: assert property (wb_ack_o |->
        $past(wb_cyc_i && wb_stb_i) && $past(wb_cyc_i && wb_stb_i, 2))
        else $error("bus ack without a two-cycle request");
    a_ans_pulse: assert property (ansValid |=> !ansValid)
        else $error("answer strobe held past one cycle");
    a_ans_code: assert property (ansValid |-> ansCode != `UBD_ANS_NONE)
        else $error("answer without a code");
    a_tx_pid: assert property (ansValid && ansCode == `UBD_ANS_GO |->
        ansTxPid == `UBD_PID_DATA0 || ansTxPid == `UBD_PID_DATA1)
        else $error("grant with a bad data pid");
    a_stall_flag: assert property (ansValid && ansCode == `UBD_ANS_STALL |->
        ##[0:2] endpoint_stall_flag != 16'h0000)
        else $error("stall answer left no endpoint flag");
    a_sync_done: assert property (syncNak |-> $past(doneValid))
        else $error("resync nak not caused by a finished transfer");
    a_sync_pulse: assert property (syncNak |=> !syncNak)
        else $error("resync nak held past one cycle");
    a_ans_hold: assert property (!ansValid |-> $stable(ansCount) && $stable(ansTxPid))
        else $error("answer fields moved between answers");
    cover property (ansValid && ansCode == `UBD_ANS_GO);
    cover property (ansValid && ansCode == `UBD_ANS_NAK);
    cover property (ansValid && ansCode == `UBD_ANS_STALL);
    cover property (syncNak);
endmodule
bind ubd_descriptor_engine ubd_engine_chk #(.AW(AW)) chk_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ansValid(ansValid), .ansCode(ansCode), .ansCount(ansCount),
    .ansTxPid(ansTxPid), .doneValid(doneValid), .syncNak(syncNak), .endpoint_stall_flag(endpoint_stall_flag));
`default_nettype wire

// ---- verif/ubd_link_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// far-side link: sends tokens, ends granted transfers
module ubd_link_model (
    input wire logic ref_clk,
    output logic tokValid,
    output logic [5:0] tokEntry,
    output logic [3:0] tokPid,
    input wire logic ansValid,
    input wire logic [1:0] ansCode,
    input wire logic [9:0] ansCount,
    input wire logic [15:0] ansAddr,
    input wire logic [3:0] ansTxPid,
    output logic doneValid,
    output logic [9:0] doneCount,
    output logic [3:0] doneRxPid,
    output logic [2:0] doneRes,
    input wire logic syncNak
);
    logic [31:0] ans; // last answer: code, count, address, pid
    int syncCnt = 0; // resync naks seen
    initial {tokValid, tokEntry, tokPid, doneValid, doneCount, doneRxPid, doneRes} = '0;
    // count resync naks
    always @(posedge ref_clk) if (syncNak === 1'b1) syncCnt <= syncCnt + 1;
    // token pulse, then wait for its answer
    task token(input logic [5:0] e, input logic [3:0] p);
        @(posedge ref_clk);
        {tokValid, tokEntry, tokPid} <= {1'b1, e, p};
        @(posedge ref_clk);
        {tokValid, tokEntry, tokPid} <= {1'b0, ~e, ~p}; // released lines wiggle
        while (ansValid !== 1'b1) @(posedge ref_clk);
        ans = {ansCode, ansCount, ansAddr, ansTxPid};
    endtask
    // end a granted transfer, leave room for a resync nak
    task finish(input logic [9:0] c, input logic [3:0] r, input logic [2:0] s);
        @(posedge ref_clk);
        {doneValid, doneCount, doneRxPid, doneRes} <= {1'b1, c, r, s};
        @(posedge ref_clk);
        {doneValid, doneCount, doneRxPid, doneRes} <= {1'b0, ~c, ~r, ~s};
        repeat (2) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ---- verif/usb_buffer_descriptor_logic_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ubd_map.vh"
module usb_buffer_descriptor_logic_tb;
    logic ref_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, tokValid, ansValid;
    logic doneValid, syncNak, irq;
    logic [9:0] wbAdr, ansCount, doneCount;
    logic [31:0] wbDatW, wbDatR, rdat;
    logic [3:0] wbSel, tokPid, ansTxPid, doneRxPid;
    logic [5:0] tokEntry;
    logic [1:0] ansCode;
    logic [15:0] ansAddr, endpoint_stall_flag;
    logic [2:0] doneRes;
    int errorCnt = 0, nCompared = 0, i;
    localparam logic [27:0] HOSTPIDS = 28'h2EA3B0F; // results 0..6
    ubd_descriptor_engine #(.AW(6)) ubd_descriptor_engine_i (.ref_clk(ref_clk),
        .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .tokValid(tokValid), .tokEntry(tokEntry), .tokPid(tokPid),
        .ansValid(ansValid), .ansCode(ansCode), .ansCount(ansCount), .ansAddr(ansAddr),
        .ansTxPid(ansTxPid), .doneValid(doneValid), .doneCount(doneCount),
        .doneRxPid(doneRxPid), .doneRes(doneRes), .syncNak(syncNak), .endpoint_stall_flag(endpoint_stall_flag),
        .irq(irq));
    ubd_link_model ubd_link_model_i (.ref_clk(ref_clk), .tokValid(tokValid),
        .tokEntry(tokEntry), .tokPid(tokPid), .ansValid(ansValid), .ansCode(ansCode),
        .ansCount(ansCount), .ansAddr(ansAddr), .ansTxPid(ansTxPid),
        .doneValid(doneValid), .doneCount(doneCount), .doneRxPid(doneRxPid),
        .doneRes(doneRes), .syncNak(syncNak));
    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // descriptor word
    function automatic logic [31:0] dw(input logic o, t, input logic [3:0] p,
        input logic [9:0] c, input logic [15:0] a);
        return {o, t, p, c, a};
    endfunction
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic bus cycle
    task wbx(input logic we, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, a, s, d};
        @(posedge ref_clk);
        while (wbAck !== 1'b1) @(posedge ref_clk);
        rdat = wbDatR;
        {wbCyc, wbStb} <= 2'b00;
    endtask
    task wr(input logic [9:0] a, input logic [31:0] d);
        wbx(1'b1, a, d, 4'hF);
    endtask
    task rd(input logic [9:0] a, input logic [31:0] exp);
        wbx(1'b0, a, 32'h0000_0000, 4'hF);
        chk(rdat, exp);
    endtask
    // token and full answer compare
    task tk(input logic [5:0] e, input logic [3:0] p, input logic [31:0] exp);
        ubd_link_model_i.token(e, p);
        chk(ubd_link_model_i.ans, exp);
    endtask
    // counts and verdict
    task stopTest;
        $display("compared %0d, mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        errorCnt++;
        $display("CHECK FAILED at %0t: run hung", $time);
        stopTest;
    end
    // test sequence
    initial begin
        {reset_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        wbSel = 4'hF;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        for (i = 0; i < 4; i++) rd(10'(`UBD_OFS_CTRL + 4 * i), 32'h0000_0000);
        rd(10'h1F0, 32'h0000_0000);
        wr(10'h1F0, 32'hFFFF_FFFF);
        rd(10'h1F0, 32'h0000_0000);
        wr(10'h0FC, 32'h1111_1111);
        wbx(1'b1, 10'h0FC, 32'hAABB_CCDD, 4'h6);
        rd(10'h0FC, 32'h11BB_CC11);
        $display("test registers done");
        wr(`UBD_OFS_MASK, 32'h0000_0001);
        wr(10'h010, dw(1'b1, 1'b0, 4'h2, 10'h040, 16'h1200));
        tk(6'd4, `UBD_TOK_OUT, {`UBD_ANS_GO, 10'h040, 16'h1200, `UBD_PID_DATA0});
        ubd_link_model_i.finish(10'h020, `UBD_PID_DATA0, 3'h0);
        rd(10'h010, dw(1'b0, 1'b0, `UBD_TOK_OUT, 10'h020, 16'h1200));
        chk(32'(irq), 32'h1);
        rd(`UBD_OFS_STAT, 32'h0000_0001);
        chk(32'(irq), 32'h0);
        $display("test receive done");
        wr(10'h020, dw(1'b0, 1'b1, 4'h3, 10'h005, 16'h0005));
        ubd_link_model_i.token(6'd8, `UBD_TOK_OUT);
        chk(32'(ubd_link_model_i.ans[31:30]), 32'(`UBD_ANS_NAK));
        rd(10'h020, dw(1'b0, 1'b1, 4'h3, 10'h005, 16'h0005));
        chk(32'(irq), 32'h0);
        rd(`UBD_OFS_STAT, 32'h0000_0004);
        $display("test unowned done");
        wr(10'h014, dw(1'b1, 1'b1, 4'h0, 10'h3FF, 16'hFFFF));
        tk(6'd5, `UBD_TOK_IN, {`UBD_ANS_GO, 10'h3FF, 16'hFFFF, `UBD_PID_DATA1});
        ubd_link_model_i.finish(10'h3FF, `UBD_PID_DATA0, 3'h0);
        rd(10'h014, dw(1'b0, 1'b1, `UBD_TOK_IN, 10'h3FF, 16'hFFFF));
        $display("test transmit done");
        wr(10'h018, dw(1'b1, 1'b1, 4'h2, 10'h010, 16'h0300));
        tk(6'd6, `UBD_TOK_SETUP, {`UBD_ANS_GO, 10'h010, 16'h0300, `UBD_PID_DATA1});
        ubd_link_model_i.finish(10'h008, `UBD_PID_DATA0, 3'h0);
        chk(32'(ubd_link_model_i.syncCnt), 32'h1);
        rd(10'h018, dw(1'b1, 1'b1, 4'h2, 10'h010, 16'h0300));
        wr(10'h01C, dw(1'b1, 1'b1, 4'h0, 10'h010, 16'h0400));
        ubd_link_model_i.token(6'd7, `UBD_TOK_SETUP);
        ubd_link_model_i.finish(10'h00C, `UBD_PID_DATA0, 3'h0);
        rd(10'h01C, dw(1'b0, 1'b0, `UBD_TOK_SETUP, 10'h00C, 16'h0400));
        $display("test toggle done");
        wr(10'h030, dw(1'b1, 1'b0, 4'h1, 10'h004, 16'h0040));
        ubd_link_model_i.token(6'd12, `UBD_TOK_IN);
        chk(32'(ubd_link_model_i.ans[31:30]), 32'(`UBD_ANS_STALL));
        chk(32'(endpoint_stall_flag), 32'h0000_0008);
        rd(10'h030, dw(1'b1, 1'b0, 4'h1, 10'h004, 16'h0040));
        rd(`UBD_OFS_EPST, 32'h0000_0008);
        wr(`UBD_OFS_EPST, 32'h0000_0008);
        rd(`UBD_OFS_EPST, 32'h0000_0000);
        $display("test stall done");
        wr(`UBD_OFS_CTRL, 32'h0000_0001);
        for (i = 0; i < 7; i++) begin
            wr(10'h040, dw(1'b1, 1'b0, 4'h0, 10'h000, 16'h0100));
            ubd_link_model_i.token(6'd16, `UBD_TOK_IN);
            ubd_link_model_i.finish(10'(i), (i == 4) ? `UBD_PID_DATA1 : `UBD_PID_DATA0, 3'(i));
            rd(10'h040, dw(1'b0, i == 4, HOSTPIDS[27 - 4 * i -: 4], 10'(i), 16'h0100));
        end
        $display("test host done");
        stopTest;
    end
endmodule
`default_nettype wire
